//--- pwm_pkg.sv
// Package: register map, field layouts, reset values and enumerations for the PWM block
package pwm_pkg;
   localparam int CNT_W = 16;
   localparam logic [3:0] OFS_PERIOD = 4'h0;
   localparam logic [3:0] OFS_CMP_A = 4'h1;
   localparam logic [3:0] OFS_CMP_B = 4'h2;
   localparam logic [3:0] OFS_COUNT = 4'h3;
   localparam logic [3:0] OFS_TBCTL = 4'h4;
   localparam logic [3:0] OFS_CMPCTL = 4'h5;
   localparam logic [3:0] OFS_ACTA = 4'h6;
   localparam logic [3:0] OFS_ACTB = 4'h7;
   localparam logic [3:0] OFS_FORCE = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'h9;
   // Field positions in the action control word
   localparam int ACT_ZERO = 0;
   localparam int ACT_PERIOD = 2;
   localparam int ACT_A_UP = 4;
   localparam int ACT_A_DN = 6;
   localparam int ACT_B_UP = 8;
   localparam int ACT_B_DN = 10;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_CLEAR = 2'h1;
   localparam logic [1:0] ACT_SET = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [11:0] ACT_RESET = 12'h000;
   localparam logic [CNT_W-1:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
   localparam logic [1:0] MODE_UP = 2'h0;
   localparam logic [1:0] MODE_UPDOWN = 2'h2;
   localparam logic [1:0] MODE_STOP = 2'h3;
   localparam logic [1:0] MODE_RESET = 2'h3;
   localparam logic LOAD_ZERO = 1'b0;
   localparam logic LOAD_PERIOD = 1'b1;
endpackage

//--- pwm_cmp_if.sv
// Interface: counter state handed from the time base to the action channels
`timescale 1ns/10ps
interface pwm_cmp_if;
   logic [15:0] count;
   logic [15:0] period;
   logic up;
   logic updown;
   logic at_zero;
   logic at_period;
   modport src (output count, period, up, updown, at_zero, at_period);
   modport dst (input count, period, up, updown, at_zero, at_period);
endinterface

//--- pwm_action_ch.sv
// Action channel: event qualification and one output with shadowed compares
`timescale 1ns/10ps
module pwm_action_ch
(
   input wire logic MCLK,
   input wire logic RST_N,
   pwm_cmp_if.dst tb,
   input wire logic [15:0] cmp_a_value,
   input wire logic [15:0] cmp_b_value,
   input wire logic [11:0] action_ctrl,
   input wire logic [1:0] force_act,
   input wire logic force_stb,
   output logic pwm_out
);
   typedef struct packed
   {
      logic out;
   } ch_s;
   ch_s st_r;
   ch_s st_nxt;
   logic a_up_hit, a_dn_hit, b_up_hit, b_dn_hit;

   function automatic logic apply(input logic cur, input logic [1:0] act);
      case (act)
         pwm_pkg::ACT_CLEAR: apply = 1'b0;
         pwm_pkg::ACT_SET: apply = 1'b1;
         pwm_pkg::ACT_TOGGLE: apply = ~cur;
         default: apply = cur;
      endcase
   endfunction

   function automatic logic [1:0] fld(input logic [11:0] c, input logic hit, input int p);
      fld = hit ? c[p +: 2] : 2'h0;
   endfunction

   // Compare events use only active values; above-period compares never match up-count
   always_comb
   begin
      a_up_hit = 1'b0;
      a_dn_hit = 1'b0;
      b_up_hit = 1'b0;
      b_dn_hit = 1'b0;
      if (tb.updown)
      begin
         // Compares at or beyond period fire at the period turn both ways, for symmetry
         a_up_hit = (cmp_a_value >= tb.period) ? tb.at_period
                    : (tb.up && tb.count == cmp_a_value);
         a_dn_hit = (cmp_a_value >= tb.period) ? tb.at_period
                    : (!tb.up && tb.count == cmp_a_value);
         b_up_hit = (cmp_b_value >= tb.period) ? tb.at_period
                    : (tb.up && tb.count == cmp_b_value);
         b_dn_hit = (cmp_b_value >= tb.period) ? tb.at_period
                    : (!tb.up && tb.count == cmp_b_value);
      end
      else
      begin
         a_up_hit = (cmp_a_value <= tb.period) && (tb.count == cmp_a_value);
         b_up_hit = (cmp_b_value <= tb.period) && (tb.count == cmp_b_value);
      end
   end

   // Lowest priority applied first so later-in-time events overwrite it
   always_comb
   begin
      st_nxt = st_r;
      if (tb.updown)
      begin
         if (tb.up)
         begin
            // The period turn still reads as up, so its action sits lowest here
            st_nxt.out = apply(st_nxt.out,
                               fld(action_ctrl, tb.at_period, pwm_pkg::ACT_PERIOD));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, a_dn_hit, pwm_pkg::ACT_A_DN));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, b_dn_hit, pwm_pkg::ACT_B_DN));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, tb.at_zero, pwm_pkg::ACT_ZERO));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, a_up_hit, pwm_pkg::ACT_A_UP));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, b_up_hit, pwm_pkg::ACT_B_UP));
         end
         else
         begin
            // Zero is reached while still counting down, so its action sits lowest here
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, tb.at_zero, pwm_pkg::ACT_ZERO));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, a_up_hit, pwm_pkg::ACT_A_UP));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, b_up_hit, pwm_pkg::ACT_B_UP));
            st_nxt.out = apply(st_nxt.out,
                               fld(action_ctrl, tb.at_period, pwm_pkg::ACT_PERIOD));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, a_dn_hit, pwm_pkg::ACT_A_DN));
            st_nxt.out = apply(st_nxt.out, fld(action_ctrl, b_dn_hit, pwm_pkg::ACT_B_DN));
         end
      end
      else
      begin
         // Zero and period coincide in up mode only when period is 0, else they fall on adjacent ticks
         st_nxt.out = apply(st_nxt.out,
                            fld(action_ctrl, tb.at_zero, pwm_pkg::ACT_ZERO));
         st_nxt.out = apply(st_nxt.out, fld(action_ctrl, a_up_hit, pwm_pkg::ACT_A_UP));
         st_nxt.out = apply(st_nxt.out, fld(action_ctrl, b_up_hit, pwm_pkg::ACT_B_UP));
         st_nxt.out = apply(st_nxt.out,
                            fld(action_ctrl, tb.at_period, pwm_pkg::ACT_PERIOD));
      end
      if (force_stb)
         st_nxt.out = apply(st_nxt.out, force_act);
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign pwm_out = st_r.out;
endmodule

//--- pwm_action_gen.sv
// Top: register file, time-base counter, compare shadowing and two action channels
`timescale 1ns/10ps
module pwm_action_gen
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic PWM_OUT_A,
   output logic PWM_OUT_B
);
   typedef struct packed
   {
      logic [15:0] period_value;
      logic [15:0] period_shadow;
      logic [15:0] compare_a_value;
      logic [15:0] compare_a_shadow;
      logic [15:0] compare_b_value;
      logic [15:0] compare_b_shadow;
      logic [15:0] timebase_count;
      logic up;
      logic [1:0] count_direction_mode;
      logic period_buffer_select;
      logic compare_a_load_point;
      logic compare_b_load_point;
      logic compare_a_buffer_select;
      logic compare_b_buffer_select;
      logic [11:0] output_a_action_control;
      logic [11:0] output_b_action_control;
      logic [15:0] rdata;
   } top_s;
   top_s st_r;
   top_s st_nxt;
   logic run, at_zero, at_period, load_zero, load_per;
   logic force_a_stb, force_b_stb;

   pwm_cmp_if tbi();

   // Load point match; one of the two events happens at most once per period
   function automatic logic load_now(input logic sel, input logic z, input logic p);
      load_now = (sel == pwm_pkg::LOAD_PERIOD) ? p : z;
   endfunction

   assign run = st_r.count_direction_mode != pwm_pkg::MODE_STOP;
   assign at_zero = run && st_r.timebase_count == 16'h0000;
   assign at_period = run && st_r.timebase_count == st_r.period_value;
   assign load_zero = at_zero;
   assign load_per = at_period;
   assign force_a_stb = WR && ADDR == pwm_pkg::OFS_FORCE && WDATA[2];
   assign force_b_stb = WR && ADDR == pwm_pkg::OFS_FORCE && WDATA[5];

   always_comb
   begin
      st_nxt = st_r;
      // Time base
      if (st_r.count_direction_mode == pwm_pkg::MODE_UP)
      begin
         st_nxt.up = 1'b1;
         if (at_period || st_r.timebase_count > st_r.period_value)
            st_nxt.timebase_count = 16'h0000;
         else
            st_nxt.timebase_count = st_r.timebase_count + 16'h0001;
      end
      else if (st_r.count_direction_mode == pwm_pkg::MODE_UPDOWN)
      begin
         if (st_r.up && (at_period || st_r.timebase_count > st_r.period_value))
         begin
            st_nxt.up = 1'b0;
            st_nxt.timebase_count = st_r.timebase_count - 16'h0001;
         end
         else if (!st_r.up && at_zero)
         begin
            st_nxt.up = 1'b1;
            st_nxt.timebase_count = 16'h0001;
         end
         else if (st_r.up)
            st_nxt.timebase_count = st_r.timebase_count + 16'h0001;
         else
            st_nxt.timebase_count = st_r.timebase_count - 16'h0001;
      end
      // Period shadow follows the zero point
      if (st_r.period_buffer_select && load_zero)
         st_nxt.period_value = st_r.period_shadow;
      // Shadow transfer, old value stays in force until the load point passes
      if (st_r.compare_a_buffer_select
          && load_now(st_r.compare_a_load_point, load_zero, load_per))
         st_nxt.compare_a_value = st_r.compare_a_shadow;
      if (st_r.compare_b_buffer_select
          && load_now(st_r.compare_b_load_point, load_zero, load_per))
         st_nxt.compare_b_value = st_r.compare_b_shadow;
      // Register writes; a direct write beats a same-cycle shadow copy
      if (WR)
      begin
         case (ADDR)
            pwm_pkg::OFS_PERIOD:
            begin
               st_nxt.period_shadow = WDATA;
               if (!st_r.period_buffer_select)
                  st_nxt.period_value = WDATA;
            end
            pwm_pkg::OFS_CMP_A:
            begin
               st_nxt.compare_a_shadow = WDATA;
               if (!st_r.compare_a_buffer_select)
                  st_nxt.compare_a_value = WDATA;
            end
            pwm_pkg::OFS_CMP_B:
            begin
               st_nxt.compare_b_shadow = WDATA;
               if (!st_r.compare_b_buffer_select)
                  st_nxt.compare_b_value = WDATA;
            end
            pwm_pkg::OFS_COUNT:
            begin
               st_nxt.timebase_count = WDATA;
               st_nxt.up = 1'b1;
            end
            pwm_pkg::OFS_TBCTL:
            begin
               st_nxt.count_direction_mode = WDATA[1:0];
               st_nxt.period_buffer_select = WDATA[3];
            end
            pwm_pkg::OFS_CMPCTL:
            begin
               st_nxt.compare_a_load_point = WDATA[0];
               st_nxt.compare_b_load_point = WDATA[2];
               st_nxt.compare_a_buffer_select = WDATA[4];
               st_nxt.compare_b_buffer_select = WDATA[6];
            end
            pwm_pkg::OFS_ACTA: st_nxt.output_a_action_control = WDATA[11:0];
            pwm_pkg::OFS_ACTB: st_nxt.output_b_action_control = WDATA[11:0];
            default: ;
         endcase
      end
      // Read data stands only in the cycle after the strobe
      st_nxt.rdata = 16'h0000;
      if (RD)
      begin
         case (ADDR)
            pwm_pkg::OFS_PERIOD: st_nxt.rdata = st_r.period_value;
            pwm_pkg::OFS_CMP_A: st_nxt.rdata = st_r.compare_a_value;
            pwm_pkg::OFS_CMP_B: st_nxt.rdata = st_r.compare_b_value;
            pwm_pkg::OFS_COUNT: st_nxt.rdata = st_r.timebase_count;
            pwm_pkg::OFS_TBCTL:
               st_nxt.rdata = {12'h000, st_r.period_buffer_select, 1'b0,
                               st_r.count_direction_mode};
            pwm_pkg::OFS_CMPCTL:
               st_nxt.rdata = {9'h000, st_r.compare_b_buffer_select, 1'b0,
                               st_r.compare_a_buffer_select, 1'b0,
                               st_r.compare_b_load_point, 1'b0, st_r.compare_a_load_point};
            pwm_pkg::OFS_ACTA: st_nxt.rdata = {4'h0, st_r.output_a_action_control};
            pwm_pkg::OFS_ACTB: st_nxt.rdata = {4'h0, st_r.output_b_action_control};
            pwm_pkg::OFS_STATUS:
               st_nxt.rdata = {13'h0000, at_period, at_zero, st_r.up};
            default: st_nxt.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_r <= '0;
         st_r.period_value <= pwm_pkg::PERIOD_RESET;
         st_r.period_shadow <= pwm_pkg::PERIOD_RESET;
         st_r.compare_a_value <= pwm_pkg::CMP_RESET;
         st_r.compare_b_value <= pwm_pkg::CMP_RESET;
         st_r.up <= 1'b1;
         st_r.count_direction_mode <= pwm_pkg::MODE_RESET;
         st_r.output_a_action_control <= pwm_pkg::ACT_RESET;
         st_r.output_b_action_control <= pwm_pkg::ACT_RESET;
      end
      else
         st_r <= st_nxt;
   end

   assign tbi.count = st_r.timebase_count;
   assign tbi.period = st_r.period_value;
   assign tbi.up = st_r.up;
   assign tbi.updown = st_r.count_direction_mode == pwm_pkg::MODE_UPDOWN;
   assign tbi.at_zero = at_zero;
   assign tbi.at_period = at_period;

   // Each channel sees compare A in its A slots and compare B in its B slots, so either output can act on both compares
   pwm_action_ch ch_a
   (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .tb(tbi),
      .cmp_a_value(st_r.compare_a_value),
      .cmp_b_value(st_r.compare_b_value),
      .action_ctrl(st_r.output_a_action_control),
      .force_act(WDATA[1:0]),
      .force_stb(force_a_stb),
      .pwm_out(PWM_OUT_A)
   );

   pwm_action_ch ch_b
   (
      .MCLK(MCLK),
      .RST_N(RST_N),
      .tb(tbi),
      .cmp_a_value(st_r.compare_a_value),
      .cmp_b_value(st_r.compare_b_value),
      .action_ctrl(st_r.output_b_action_control),
      .force_act(WDATA[4:3]),
      .force_stb(force_b_stb),
      .pwm_out(PWM_OUT_B)
   );

   assign RDATA = st_r.rdata;
endmodule

//--- pwm_action_gen_checker.sv
// Checker: port-level assertions for the PWM block
`timescale 1ns/10ps
module pwm_action_gen_checker
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic PWM_OUT_A,
   input wire logic PWM_OUT_B
);
   logic [1:0] mode_r;
   logic written_r;
   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);
   // Mode mirror lets count steps be judged without a full register model
   always_ff @(posedge MCLK or negedge RST_N)
      if (!RST_N)
      begin
         mode_r <= pwm_pkg::MODE_RESET;
         written_r <= 1'b0;
      end
      else
      begin
         if (WR && ADDR == pwm_pkg::OFS_TBCTL)
            mode_r <= WDATA[1:0];
         if (WR && ADDR >= pwm_pkg::OFS_ACTA && ADDR <= pwm_pkg::OFS_FORCE)
            written_r <= 1'b1;
      end
   chk_read_idle: assert property (!RD |=> RDATA == 16'h0000)
      else $error("read data not zero outside a read");
   chk_unmapped_read: assert property (RD && ADDR > pwm_pkg::OFS_STATUS |=> RDATA == 16'h0000)
      else $error("unmapped read returned data");
   chk_action_width: assert property (
      RD && (ADDR == pwm_pkg::OFS_ACTA || ADDR == pwm_pkg::OFS_ACTB) |=> RDATA[15:12] == 4'h0)
      else $error("action word has bits above its fields");
   chk_quiet_reset: assert property (!written_r |-> !PWM_OUT_A && !PWM_OUT_B)
      else $error("output moved with every action still none");
   chk_force_set: assert property (
      WR && ADDR == pwm_pkg::OFS_FORCE && WDATA[2] && WDATA[1:0] == pwm_pkg::ACT_SET
      |=> PWM_OUT_A)
      else $error("forced set on output A not applied");
   chk_force_clear: assert property (
      WR && ADDR == pwm_pkg::OFS_FORCE && WDATA[5] && WDATA[4:3] == pwm_pkg::ACT_CLEAR
      |=> !PWM_OUT_B)
      else $error("forced clear on output B not applied");
   chk_force_toggle: assert property (
      WR && ADDR == pwm_pkg::OFS_FORCE && WDATA[2] && WDATA[1:0] == pwm_pkg::ACT_TOGGLE
      |=> PWM_OUT_A != $past(PWM_OUT_A))
      else $error("forced toggle on output A not applied");
   chk_up_step: assert property (
      RD && !WR && ADDR == pwm_pkg::OFS_COUNT && mode_r == pwm_pkg::MODE_UP
      ##1 RD && !WR && ADDR == pwm_pkg::OFS_COUNT
      |=> RDATA == $past(RDATA) + 16'h0001 || RDATA == 16'h0000)
      else $error("up count did not step by one or wrap");
   chk_updown_step: assert property (
      RD && !WR && ADDR == pwm_pkg::OFS_COUNT && mode_r == pwm_pkg::MODE_UPDOWN
      ##1 RD && !WR && ADDR == pwm_pkg::OFS_COUNT
      |=> RDATA == $past(RDATA) + 16'h0001 || RDATA == $past(RDATA) - 16'h0001)
      else $error("up-down count did not step by one");
   chk_status_up: assert property (
      RD && !WR && ADDR == pwm_pkg::OFS_STATUS && mode_r == pwm_pkg::MODE_UP |=> RDATA[0])
      else $error("direction not up in up mode");
endmodule
bind pwm_action_gen pwm_action_gen_checker chk_u (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PWM_OUT_A(PWM_OUT_A),
   .PWM_OUT_B(PWM_OUT_B));

//--- pwm_switch_model.sv
// Partner: switch driver that measures pulse high time and period of its input
`timescale 1ns/10ps
module pwm_switch_model
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic drive,
   output logic [15:0] high_ticks,
   output logic [15:0] period_ticks
);
   logic last_r;
   logic [15:0] run_r;
   // Figures refresh only on edges, so a stuck output keeps stale values
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         last_r <= 1'b0;
         run_r <= 16'h0000;
         high_ticks <= 16'h0000;
         period_ticks <= 16'h0000;
      end
      else
      begin
         last_r <= drive;
         run_r <= (drive && !last_r) ? 16'h0001 : run_r + 16'h0001;
         if (drive && !last_r)
            period_ticks <= run_r;
         if (!drive && last_r)
            high_ticks <= run_r;
      end
endmodule

//--- tb.sv
// Testbench: registers, waveform timing and forced actions of the PWM block
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic out_a;
   logic out_b;
   logic [15:0] hi_a;
   logic [15:0] per_a;
   logic [15:0] hi_b;
   logic [15:0] per_b;
   logic [15:0] d;
   int bad_count = 0;
   int compares = 0;
   always #5 mclk = ~mclk;
   pwm_action_gen dut_u (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .PWM_OUT_A(out_a), .PWM_OUT_B(out_b));
   pwm_switch_model sw_a_u (.clk(mclk), .rst_n(rst_n), .drive(out_a), .high_ticks(hi_a),
      .period_ticks(per_a));
   pwm_switch_model sw_b_u (.clk(mclk), .rst_n(rst_n), .drive(out_b), .high_ticks(hi_b),
      .period_ticks(per_b));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(posedge mclk);
      d = rdata;
   endtask
   // Two reads on adjacent cycles; in up mode the second is one higher or wrapped
   task automatic count_step(input logic [15:0] p, input logic judge);
      logic [15:0] c0;
      @(posedge mclk);
      rd <= 1'b1;
      addr <= pwm_pkg::OFS_COUNT;
      repeat (2) @(posedge mclk);
      rd <= 1'b0;
      c0 = rdata;
      @(posedge mclk);
      if (judge)
         check(rdata, (c0 == p) ? 16'h0000 : c0 + 16'h0001);
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic levels(input int n, input logic [1:0] e, input logic [1:0] m);
      repeat (n)
      begin
         @(posedge mclk);
         check({14'h0, {out_a, out_b} & m}, {14'h0, e & m});
      end
   endtask
   task automatic meas(input logic [15:0] ha, pa, hb, pb);
      check(hi_a, ha);
      check(per_a, pa);
      check(hi_b, hb);
      check(per_b, pb);
   endtask
   task automatic start(input logic [1:0] mode, input logic [15:0] p, ca, cb, aa, ab);
      wr_reg(pwm_pkg::OFS_TBCTL, {14'h0, pwm_pkg::MODE_STOP});
      wr_reg(pwm_pkg::OFS_PERIOD, p);
      wr_reg(pwm_pkg::OFS_CMP_A, ca);
      wr_reg(pwm_pkg::OFS_CMP_B, cb);
      wr_reg(pwm_pkg::OFS_ACTA, aa);
      wr_reg(pwm_pkg::OFS_ACTB, ab);
      wr_reg(pwm_pkg::OFS_COUNT, 16'h0000);
      wr_reg(pwm_pkg::OFS_TBCTL, {14'h0, mode});
   endtask
   task automatic test_reset();
      rd_reg(pwm_pkg::OFS_PERIOD);
      check(d, pwm_pkg::PERIOD_RESET);
      rd_reg(pwm_pkg::OFS_ACTA);
      check(d, {4'h0, pwm_pkg::ACT_RESET});
      rd_reg(pwm_pkg::OFS_ACTB);
      check(d, {4'h0, pwm_pkg::ACT_RESET});
      rd_reg(4'hF);
      check(d, 16'h0000);
      levels(8, 2'b00, 2'b11);
      $display("test reset done");
   endtask
   task automatic test_up();
      wr_reg(pwm_pkg::OFS_CMPCTL, 16'h0055);
      start(pwm_pkg::MODE_UP, 16'h0007, 16'h0003, 16'h0005, 16'h0012, 16'h0102);
      pause(40);
      meas(16'h0003, 16'h0008, 16'h0005, 16'h0008);
      count_step(16'h0007, 1'b1);
      rd_reg(pwm_pkg::OFS_STATUS);
      check(d & 16'h0001, 16'h0001);
      wr_reg(pwm_pkg::OFS_CMP_A, 16'h0008);
      wr_reg(pwm_pkg::OFS_ACTB, 16'h0009);
      pause(30);
      levels(20, 2'b10, 2'b10);
      check(hi_b, 16'h0001);
      $display("test up done");
   endtask
   task automatic test_updown();
      wr_reg(pwm_pkg::OFS_CMPCTL, 16'h0050);
      start(pwm_pkg::MODE_UPDOWN, 16'h0006, 16'h0002, 16'h0003, 16'h0060, 16'h0600);
      pause(50);
      meas(16'h0008, 16'h000C, 16'h0006, 16'h000C);
      count_step(16'h0006, 1'b0);
      wr_reg(pwm_pkg::OFS_CMP_A, 16'h0000);
      wr_reg(pwm_pkg::OFS_CMP_B, 16'h0006);
      pause(40);
      levels(24, 2'b01, 2'b11);
      $display("test updown done");
   endtask
   task automatic test_dual();
      wr_reg(pwm_pkg::OFS_CMPCTL, 16'h0000);
      start(pwm_pkg::MODE_UP, 16'h0009, 16'h0002, 16'h0006, 16'h0120, 16'h0003);
      pause(70);
      meas(16'h0004, 16'h000A, 16'h000A, 16'h0014);
      $display("test dual done");
   endtask
   // Period actions only work if the turn points reach the action logic
   task automatic test_asym();
      wr_reg(pwm_pkg::OFS_CMPCTL, 16'h0011);
      start(pwm_pkg::MODE_UPDOWN, 16'h0006, 16'h0001, 16'h0000, 16'h0024, 16'h0000);
      pause(50);
      check(hi_a, 16'h0005);
      check(per_a, 16'h000C);
      start(pwm_pkg::MODE_UP, 16'h0009, 16'h0003, 16'h0000, 16'h0024, 16'h0000);
      wr_reg(pwm_pkg::OFS_TBCTL, {12'h000, 1'b1, 1'b0, pwm_pkg::MODE_UP});
      wr_reg(pwm_pkg::OFS_PERIOD, 16'h000A);
      pause(40);
      check(hi_a, 16'h0007);
      check(per_a, 16'h000B);
      rd_reg(pwm_pkg::OFS_PERIOD);
      check(d, 16'h000A);
      $display("test asym done");
   endtask
   task automatic test_force();
      logic [15:0] cmd [8] = '{16'h002E, 16'h0030, 16'h0007, 16'h0028, 16'h0007, 16'h0005,
         16'h0004, 16'h0038};
      logic [1:0] exp [8] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b10, 2'b00, 2'b00, 2'b01};
      start(pwm_pkg::MODE_STOP, 16'h0009, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(pwm_pkg::OFS_FORCE, cmd[i]);
         levels(2, exp[i], 2'b11);
      end
      $display("test force done");
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      test_reset();
      test_up();
      test_updown();
      test_dual();
      test_asym();
      test_force();
      finish_test();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge mclk);
      bad_count++;
      finish_test();
   end
endmodule
